// *** core/scc_top.sv ***
// Scan cycle control: Wishbone registers, scan sequencer and monitor select
`timescale 1ns/1ps

// Operation
// - Stop command ends scan, invalidates list
// - Interface clear halts interface-started scan
// - Stop honoured under bus or hold trigger
// - Stopped scan restarts only on launch
// - One launch runs stored cycle count in single mode
// - Min keyword loads 1, max 32767
// - Plain query returns stored count
// - Min query returns 1, max 32767
// - Monitor select takes card 1-99 or auto
// - Auto monitors last switched module
// - Launch closes first listed channel
// - Each trigger after a closure advances to next channel
// - Continuous mode wraps to first channel
// - Single mode opens last channel at end
module scc_top
(
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          ifcClearPin,
   input  wire logic          extTrigPin,
   output logic               chanCloseStb,
   output logic      [15:0]   chanClose,
   output logic               chanOpenStb,
   output logic      [15:0]   chanOpen,
   output logic               scanActive,
   output logic      [6:0]    monCard
);

   typedef struct packed {
      logic                          ack;
      logic [31:0]                   rdat;
      logic                          cont;
      scc_pkg::scc_tsrc_e            tsrc;
      logic [scc_pkg::CYC_W-1:0]     cycles;
      logic [4:0]                    listLen;
      logic                          listValid;
      scc_pkg::scc_state_e           state;
      logic                          active;
      logic [scc_pkg::IDX_W-1:0]     idx;
      logic [scc_pkg::CYC_W-1:0]     cycLeft;
      logic                          ifStarted;
      logic                          haveClosed;
      logic [scc_pkg::CHAN_W-1:0]    curChan;
      logic                          busTrig;
      logic [1:0]                    ifcSync;
      logic [1:0]                    trigSync;
      logic                          ifcPrev;
      logic                          trigPrev;
      logic                          closeStb;
      logic [scc_pkg::CHAN_W-1:0]    closeChan;
      logic                          openStb;
      logic [scc_pkg::CHAN_W-1:0]    openChan;
   } scc_top_s;

   scc_top_s st_q;
   scc_top_s st_d;

   logic [scc_pkg::CHAN_W-1:0]   memRdData;
   logic                         memWe;
   logic [scc_pkg::IDX_W-1:0]    memWrAddr;
   logic                         monSelWe;
   logic                         swWe;
   logic                         monAuto;
   logic [scc_pkg::CARD_W-1:0]   monFixed;
   logic [scc_pkg::CARD_W-1:0]   monCardW;

   // Address decode helpers used by the write path only
   function automatic logic isList(input logic [7:0] a);
      return a[7:6] == scc_pkg::OFS_LIST_BASE[7:6];
   endfunction

   function automatic logic [scc_pkg::IDX_W-1:0] listIdx(input logic [7:0] a);
      return a[scc_pkg::IDX_W+1:2];
   endfunction

   // A write is accepted only as a full word at the edge the master sees ack
   logic busWrite;
   logic busRead;
   assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack && (wb_sel_i == 4'hF);
   assign busRead  = wb_cyc_i && wb_stb_i && !wb_we_i && !st_q.ack;

   assign memWe     = busWrite && isList(wb_adr_i);
   assign memWrAddr = listIdx(wb_adr_i);
   assign monSelWe  = busWrite && (wb_adr_i == scc_pkg::OFS_MON);
   assign swWe      = busWrite && (wb_adr_i == scc_pkg::OFS_SWITCH);

   scc_chan_mem u_mem
   (
      .clk    (clk),
      .we     (memWe),
      .wrAddr (memWrAddr),
      .wrData (wb_dat_i[scc_pkg::CHAN_W-1:0]),
      .rdAddr (st_d.idx),
      .rdData (memRdData)
   );

   scc_mon_sel u_mon
   (
      .clk       (clk),
      .srst      (srst),
      .selWe     (monSelWe),
      .selAuto   (wb_dat_i[scc_pkg::MON_AUTO]),
      .selCard   (wb_dat_i[scc_pkg::CARD_W-1:0]),
      .swWe      (swWe),
      .swCard    (wb_dat_i[scc_pkg::CARD_W-1:0]),
      .autoMode  (monAuto),
      .fixedCard (monFixed),
      .monCard   (monCardW)
   );

   // Next state of the whole block
   always_comb
   begin
      logic launch;
      logic stop;
      logic ifcEdge;
      logic trig;
      logic lastIdx;
      logic busHit;
      busHit  = 1'b0;
      launch  = 1'b0;
      stop    = 1'b0;
      ifcEdge = 1'b0;
      trig    = 1'b0;
      lastIdx = 1'b0;
      st_d = st_q;

      // Pins pass two flops; edges are taken past the second one only
      st_d.ifcSync  = {st_q.ifcSync[0], ifcClearPin};
      st_d.trigSync = {st_q.trigSync[0], extTrigPin};
      st_d.ifcPrev  = st_q.ifcSync[1];
      st_d.trigPrev = st_q.trigSync[1];
      ifcEdge = st_q.ifcSync[1] && !st_q.ifcPrev;

      // Wishbone: ack one cycle after the request, dropped the next cycle
      st_d.ack  = wb_cyc_i && wb_stb_i && !st_q.ack;
      st_d.rdat = 32'h0000_0000;
      if (busRead)
      begin
         // List entries never match a case item, so they read zero with unmapped ones
         case (wb_adr_i)
            scc_pkg::OFS_CTRL:
            begin
               st_d.rdat[scc_pkg::CTRL_CONT] = st_q.cont;
               st_d.rdat[scc_pkg::CTRL_TSRC_HI:scc_pkg::CTRL_TSRC_LO] = st_q.tsrc;
            end
            scc_pkg::OFS_CYC:
            begin
               st_d.rdat[scc_pkg::CYC_W-1:0] = st_q.cycles;
            end
            scc_pkg::OFS_CYC_MIN:
            begin
               st_d.rdat[scc_pkg::CYC_W-1:0] = scc_pkg::CYC_MIN;
            end
            scc_pkg::OFS_CYC_MAX:
            begin
               st_d.rdat[scc_pkg::CYC_W-1:0] = scc_pkg::CYC_MAX;
            end
            scc_pkg::OFS_MON:
            begin
               st_d.rdat[scc_pkg::CARD_W-1:0] = monAuto ? monCardW : monFixed;
               st_d.rdat[scc_pkg::MON_AUTO]   = monAuto;
            end
            scc_pkg::OFS_LIST_LEN:
            begin
               st_d.rdat[4:0] = st_q.listLen;
            end
            scc_pkg::OFS_STATUS:
            begin
               st_d.rdat[scc_pkg::ST_ACTIVE] = (st_q.state != scc_pkg::S_IDLE);
               st_d.rdat[scc_pkg::ST_VALID]  = st_q.listValid;
               st_d.rdat[scc_pkg::ST_IFSTRT] = st_q.ifStarted;
               st_d.rdat[scc_pkg::ST_IDX_LO +: scc_pkg::IDX_W] = st_q.idx;
               st_d.rdat[scc_pkg::ST_CYC_LO +: scc_pkg::CYC_W] = st_q.cycLeft;
            end
            default:
            begin
               st_d.rdat = 32'h0000_0000;                      // List is write only
            end
         endcase
      end

      // Register writes
      if (busWrite)
      begin
         case (wb_adr_i)
            scc_pkg::OFS_CMD:
            begin
               launch = wb_dat_i[scc_pkg::CMD_LAUNCH];
               stop   = wb_dat_i[scc_pkg::CMD_STOP];
               busHit = wb_dat_i[scc_pkg::CMD_BUS_TRIG];
               st_d.busTrig = st_q.busTrig || busHit;
            end
            scc_pkg::OFS_CTRL:
            begin
               st_d.cont = wb_dat_i[scc_pkg::CTRL_CONT];
               st_d.tsrc = scc_pkg::scc_tsrc_e'(
                  wb_dat_i[scc_pkg::CTRL_TSRC_HI:scc_pkg::CTRL_TSRC_LO]);
            end
            scc_pkg::OFS_CYC:
            begin
               // Keywords win over the number; zero or oversize values are dropped
               if (wb_dat_i[scc_pkg::CYC_KEY_MIN])
               begin
                  st_d.cycles = scc_pkg::CYC_MIN;
               end
               else if (wb_dat_i[scc_pkg::CYC_KEY_MAX])
               begin
                  st_d.cycles = scc_pkg::CYC_MAX;
               end
               else if (wb_dat_i[15:0] != 16'h0000 && !wb_dat_i[15])
               begin
                  st_d.cycles = wb_dat_i[scc_pkg::CYC_W-1:0];
               end
            end
            scc_pkg::OFS_LIST_LEN:
            begin
               if (wb_dat_i[4:0] != 5'h00 && wb_dat_i[4:0] <= scc_pkg::LEN_MAX)
               begin
                  st_d.listLen   = wb_dat_i[4:0];
                  st_d.listValid = 1'b1;
               end
            end
            default:
            begin
               st_d.listLen = st_d.listLen;                    // Others ignored here
            end
         endcase
      end

      // Advance source for the scan
      case (st_q.tsrc)
         scc_pkg::TS_IMM:  trig = 1'b1;
         scc_pkg::TS_BUS:  trig = st_q.busTrig;
         scc_pkg::TS_EXT:  trig = st_q.trigSync[1] && !st_q.trigPrev;
         default:          trig = 1'b0;                        // Hold never advances
      endcase

      st_d.closeStb = 1'b0;
      st_d.openStb  = 1'b0;
      lastIdx = ({1'b0, st_q.idx} == (st_q.listLen - 5'h01));

      // Scan sequencer
      case (st_q.state)
         scc_pkg::S_IDLE:
         begin
            // Only a launch leaves idle, and only with a defined list
            if (launch && st_q.listValid)
            begin
               st_d.state     = scc_pkg::S_FETCH;
               st_d.idx       = '0;
               st_d.cycLeft   = st_q.cycles;
               st_d.ifStarted = 1'b1;
            end
         end
         scc_pkg::S_FETCH:
         begin
            st_d.state = scc_pkg::S_CLOSE;                      // Memory read latency
         end
         scc_pkg::S_CLOSE:
         begin
            // Open and close share a cycle: the old channel opens in the cycle the new one closes
            st_d.openStb    = st_q.haveClosed;
            st_d.openChan   = st_q.curChan;
            st_d.closeStb   = 1'b1;
            st_d.closeChan  = memRdData;
            st_d.curChan    = memRdData;
            st_d.haveClosed = 1'b1;
            st_d.busTrig    = 1'b0;                             // Triggers before closure drop
            st_d.state      = scc_pkg::S_WAIT;
         end
         scc_pkg::S_WAIT:
         begin
            if (trig)
            begin
               st_d.busTrig = busHit;                           // A trigger landing now is kept
               if (!lastIdx)
               begin
                  st_d.idx   = st_q.idx + 4'h1;
                  st_d.state = scc_pkg::S_FETCH;
               end
               else if (st_q.cont)
               begin
                  st_d.idx   = '0;
                  st_d.state = scc_pkg::S_FETCH;
               end
               else if (st_q.cycLeft > scc_pkg::CYC_MIN)
               begin
                  st_d.idx     = '0;
                  st_d.cycLeft = st_q.cycLeft - scc_pkg::CYC_MIN;
                  st_d.state   = scc_pkg::S_FETCH;
               end
               else
               begin
                  st_d.openStb    = 1'b1;
                  st_d.openChan   = st_q.curChan;
                  st_d.haveClosed = 1'b0;
                  st_d.ifStarted  = 1'b0;
                  st_d.state      = scc_pkg::S_IDLE;
               end
            end
         end
         default:
         begin
            st_d.state = scc_pkg::S_IDLE;
         end
      endcase

      // Stop and interface clear override the sequencer in any trigger mode
      if (stop || (ifcEdge && st_q.ifStarted))
      begin
         if (st_q.haveClosed)
         begin
            st_d.openStb  = 1'b1;
            st_d.openChan = st_q.curChan;
         end
         st_d.closeStb   = 1'b0;
         st_d.haveClosed = 1'b0;
         st_d.ifStarted  = 1'b0;
         st_d.busTrig    = 1'b0;
         st_d.state      = scc_pkg::S_IDLE;
      end
      if (stop)
      begin
         st_d.listValid = 1'b0;
      end
      st_d.active = (st_d.state != scc_pkg::S_IDLE);
   end

   // Registered copy of all state
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q        <= '0;                                     // Idle, immediate source, list invalid
         st_q.cycles <= scc_pkg::CYC_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o     = st_q.ack;
   assign wb_dat_o     = st_q.rdat;
   assign chanCloseStb = st_q.closeStb;
   assign chanClose    = st_q.closeChan;
   assign chanOpenStb  = st_q.openStb;
   assign chanOpen     = st_q.openChan;
   assign scanActive   = st_q.active;
   assign monCard      = monCardW;

endmodule // scc_top

// *** core/scc_pkg.sv ***
// Shared constants and types for the scan cycle control block
package scc_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_CMD       = 8'h00;
   localparam logic [7:0] OFS_CTRL      = 8'h04;
   localparam logic [7:0] OFS_CYC       = 8'h08;
   localparam logic [7:0] OFS_CYC_MIN   = 8'h0C;
   localparam logic [7:0] OFS_CYC_MAX   = 8'h10;
   localparam logic [7:0] OFS_MON       = 8'h14;
   localparam logic [7:0] OFS_SWITCH    = 8'h18;
   localparam logic [7:0] OFS_LIST_LEN  = 8'h1C;
   localparam logic [7:0] OFS_STATUS    = 8'h20;
   localparam logic [7:0] OFS_LIST_BASE = 8'h40;

   // Command register bits (write only, self clearing)
   localparam int CMD_LAUNCH   = 0;
   localparam int CMD_STOP     = 1;
   localparam int CMD_BUS_TRIG = 2;

   // Control register fields
   localparam int CTRL_CONT    = 0;
   localparam int CTRL_TSRC_LO = 1;
   localparam int CTRL_TSRC_HI = 2;

   // Cycle repeat setting
   localparam int          CYC_W       = 15;
   localparam int          CYC_KEY_MIN = 16;
   localparam int          CYC_KEY_MAX = 17;
   localparam logic [14:0] CYC_MIN     = 15'h0001;
   localparam logic [14:0] CYC_MAX     = 15'h7FFF;
   localparam logic [14:0] CYC_RST     = 15'h0001;

   // Monitored module selection
   localparam int         CARD_W   = 7;
   localparam int         MON_AUTO = 7;
   localparam logic [6:0] CARD_MIN = 7'h01;
   localparam logic [6:0] CARD_MAX = 7'h63;
   localparam logic [6:0] CARD_RST = 7'h01;

   // Channel list
   localparam int         CHAN_W     = 16;
   localparam int         IDX_W      = 4;
   localparam int         LIST_DEPTH = 16;
   localparam logic [4:0] LEN_MAX    = 5'h10;

   // Status register fields
   localparam int ST_ACTIVE = 0;
   localparam int ST_VALID  = 1;
   localparam int ST_IFSTRT = 2;
   localparam int ST_IDX_LO = 4;
   localparam int ST_CYC_LO = 16;

   typedef enum logic [1:0] {
      TS_IMM  = 2'b00,
      TS_BUS  = 2'b01,
      TS_HOLD = 2'b10,
      TS_EXT  = 2'b11
   } scc_tsrc_e;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_FETCH = 2'b01,
      S_CLOSE = 2'b10,
      S_WAIT  = 2'b11
   } scc_state_e;

endpackage

// *** core/scc_chan_mem.sv ***
// Channel list memory with registered read data
`timescale 1ns/1ps
module scc_chan_mem
(
   input  wire logic                          clk,
   input  wire logic                          we,
   input  wire logic [scc_pkg::IDX_W-1:0]     wrAddr,
   input  wire logic [scc_pkg::CHAN_W-1:0]    wrData,
   input  wire logic [scc_pkg::IDX_W-1:0]     rdAddr,
   output logic      [scc_pkg::CHAN_W-1:0]    rdData
);

   logic [scc_pkg::CHAN_W-1:0] mem [scc_pkg::LIST_DEPTH];

   // No reset on the array; an entry is only read after software defines the list
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule // scc_chan_mem

// *** core/scc_mon_sel.sv ***
// Monitored module selection: fixed card or follow last switched card
`timescale 1ns/1ps
module scc_mon_sel
(
   input  wire logic                          clk,
   input  wire logic                          srst,
   input  wire logic                          selWe,
   input  wire logic                          selAuto,
   input  wire logic [scc_pkg::CARD_W-1:0]    selCard,
   input  wire logic                          swWe,
   input  wire logic [scc_pkg::CARD_W-1:0]    swCard,
   output logic                               autoMode,
   output logic      [scc_pkg::CARD_W-1:0]    fixedCard,
   output logic      [scc_pkg::CARD_W-1:0]    monCard
);

   typedef struct packed {
      logic                          autoMode;
      logic [scc_pkg::CARD_W-1:0]    fixedCard;
      logic [scc_pkg::CARD_W-1:0]    lastCard;
      logic [scc_pkg::CARD_W-1:0]    monCard;
   } scc_mon_s;

   scc_mon_s st_q;
   scc_mon_s st_d;

   function automatic logic cardOk(input logic [scc_pkg::CARD_W-1:0] c);
      return (c >= scc_pkg::CARD_MIN) && (c <= scc_pkg::CARD_MAX);
   endfunction

   // Out of range card numbers are dropped so the shown card stays legal
   always_comb
   begin
      st_d = st_q;
      if (selWe && selAuto)
      begin
         st_d.autoMode = 1'b1;
      end
      else if (selWe && cardOk(selCard))
      begin
         st_d.autoMode  = 1'b0;
         st_d.fixedCard = selCard;
      end
      if (swWe && cardOk(swCard))
      begin
         st_d.lastCard = swCard;
      end
      st_d.monCard = st_d.autoMode ? st_d.lastCard : st_d.fixedCard;
   end

   // Registered copy of all state
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q.autoMode  <= 1'b1;
         st_q.fixedCard <= scc_pkg::CARD_RST;
         st_q.lastCard  <= scc_pkg::CARD_RST;
         st_q.monCard   <= scc_pkg::CARD_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign autoMode  = st_q.autoMode;
   assign fixedCard = st_q.fixedCard;
   assign monCard   = st_q.monCard;

endmodule // scc_mon_sel

// *** test/scc_top_sva.sv ***
// Port checker for the scan cycle control block
`timescale 1ns/1ps
module scc_top_sva
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        chanCloseStb,
   input wire logic        scanActive,
   input wire logic [6:0]  monCard
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic       wrDone;
   logic       fixW;
   logic [6:0] fixCard_q;
   // Completed write; partial byte enables are ignored by the slave
   assign wrDone = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_sel_i == 4'hF);
   assign fixW = wrDone && wb_adr_i == scc_pkg::OFS_MON && !wb_dat_i[7]
                 && wb_dat_i[6:0] >= 7'h01 && wb_dat_i[6:0] <= 7'h63;
   // Keep the card, since the master changes the data lines after ack
   always_ff @(posedge clk)
   begin
      if (fixW)
         fixCard_q <= wb_dat_i[6:0];
   end
   AST_ACK_LAT: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
      else $error("ack not one cycle after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RD_MIN: assert property (wb_ack_o && !wb_we_i && wb_adr_i == scc_pkg::OFS_CYC_MIN
      |-> wb_dat_o == 32'h1) else $error("min query wrong");
   AST_RD_MAX: assert property (wb_ack_o && !wb_we_i && wb_adr_i == scc_pkg::OFS_CYC_MAX
      |-> wb_dat_o == 32'h7FFF) else $error("max query wrong");
   AST_STOP: assert property (wrDone && wb_adr_i == scc_pkg::OFS_CMD && wb_dat_i[1]
      |=> !scanActive) else $error("stop did not end scan");
   AST_CLOSE_ACT: assert property (chanCloseStb |-> scanActive)
      else $error("close outside scan");
   AST_MON_FIX: assert property (fixW |-> ##[1:2] monCard == fixCard_q)
      else $error("fixed card not shown");
   AST_RESET: assert property ($fell(srst) |-> monCard == 7'h01 && !scanActive
      && !wb_ack_o) else $error("reset state wrong");
endmodule // scc_top_sva

// *** test/scc_host.sv ***
// Host model: Wishbone classic master sending register commands
`timescale 1ns/1ps
module scc_host
(
   input  wire logic        clk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dout,
   input  wire logic        ack,
   input  wire logic [31:0] din
);
   initial
   begin
      {cyc, stb, we, adr, sel, dout} = '0;
   end
   // One cycle; request held until ack is sampled, then lines scrambled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output bit ok);
      ok = 0;
      q = '0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dout <= d;
      for (int n = 0; n < 50 && !ok; n++)
      begin
         @(posedge clk);
         if (ack === 1'b1)
         begin
            ok = 1;
            q = din;
         end
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= ~w;
      adr <= ~a;
      dout <= ~d;
      @(posedge clk);
   endtask
endmodule // scc_host

// *** test/tb_top.sv ***
// Self-checking bench: register traffic, scan sequencing, monitor select
`timescale 1ns/1ps
module tb_top;
   logic        clk, srst, ifcClearPin, extTrigPin;
   logic        wbCyc, wbStb, wbWe, wbAck, closeStb, openStb, scanActive;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatI, wbDatO, q;
   logic [15:0] chanClose, chanOpen;
   logic [6:0]  monCard;
   logic [15:0] gotC[$], gotO[$], expC[$], expO[$], ch[3];
   logic [31:0] cw[7] = '{32'hA, 32'h0, 32'h8000, 32'h10000, 32'h20000, 32'h30000, 32'h7FFF};
   logic [31:0] ce[7] = '{32'hA, 32'hA, 32'hA, 32'h1, 32'h7FFF, 32'h1, 32'h7FFF};
   int          n_fail, checks_done, seed, i, k, card;
   bit          ok;
   scc_top uut (.clk(clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .ifcClearPin(ifcClearPin), .extTrigPin(extTrigPin),
      .chanCloseStb(closeStb), .chanClose(chanClose), .chanOpenStb(openStb),
      .chanOpen(chanOpen), .scanActive(scanActive), .monCard(monCard));
   scc_host host (.clk(clk), .cyc(wbCyc), .stb(wbStb), .we(wbWe), .adr(wbAdr),
      .sel(wbSel), .dout(wbDatI), .ack(wbAck), .din(wbDatO));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Record every channel strobe for comparison with the model
   always @(posedge clk)
   begin
      if (closeStb === 1'b1) gotC.push_back(chanClose);
      if (openStb === 1'b1) gotO.push_back(chanOpen);
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic hang();
      n_fail++;
      summarize();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, ok);
      if (!ok) hang();
   endtask
   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, q, ok);
      if (!ok) hang();
      chk(nm, e, q);
   endtask
   // Model sequences against recorded strobes, then start afresh
   task automatic chkSeq();
      chk("close count", expC.size(), gotC.size());
      chk("open count", expO.size(), gotO.size());
      for (k = 0; k < expC.size() && k < gotC.size(); k++) chk("close", expC[k], gotC[k]);
      for (k = 0; k < expO.size() && k < gotO.size(); k++) chk("open", expO[k], gotO[k]);
      expC.delete();
      expO.delete();
      gotC.delete();
      gotO.delete();
   endtask
   // Let the launch land first, then wait boundedly for the scan to end
   task automatic waitIdle();
      repeat (4) @(posedge clk);
      for (k = 0; k < 3000 && scanActive !== 1'b0; k++) @(posedge clk);
      if (scanActive !== 1'b0) hang();
      @(posedge clk); // Let the recorder take the final open strobe
   endtask
   initial
   begin
      seed = 32'hf8ff0572;
      n_fail = 0;
      checks_done = 0;
      srst = 1'b1;
      ifcClearPin = 1'b0;
      extTrigPin = 1'b0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      chk("mon card", 7'h01, monCard);
      rdChk("cycles", 8'h08, 32'h1);
      rdChk("mon", 8'h14, 32'h81);
      // Cycle setting: numbers, out of range values and keywords
      for (i = 0; i < 7; i++)
      begin
         wr(8'h08, cw[i]);
         rdChk("cycles", 8'h08, ce[i]);
         rdChk("min query", 8'h0C, 32'h1);
         rdChk("max query", 8'h10, 32'h7FFF);
      end
      $display("test cycle setting done");
      card = 1 + ($unsigned($random(seed)) % 99);
      wr(8'h14, card);
      wr(8'h14, 32'h64);
      wr(8'h18, 32'h7);
      repeat (3) @(posedge clk);
      chk("fixed card", card, monCard);
      wr(8'h14, 32'h80);
      repeat (3) @(posedge clk);
      chk("auto card", 32'h7, monCard);
      wr(8'h18, 32'h2A);
      repeat (3) @(posedge clk);
      chk("auto card", 32'h2A, monCard);
      $display("test monitor select done");
      // Two full cycles of three random channels, immediate trigger
      for (i = 0; i < 3; i++)
      begin
         ch[i] = 16'($random(seed));
         wr(8'h40 + 8'(4 * i), {16'h0000, ch[i]});
      end
      wr(8'h1C, 32'h3);
      wr(8'h08, 32'h2);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h1);
      waitIdle();
      for (k = 0; k < 6; k++) expC.push_back(ch[k % 3]);
      expO = expC;
      chkSeq();
      $display("test single scan done");
      // Continuous scan on bus triggers, wrap, stop, refused relaunch
      wr(8'h04, 32'h3);
      wr(8'h00, 32'h1);
      for (i = 0; i < 3; i++)
      begin
         repeat (4) @(posedge clk);
         wr(8'h00, 32'h4);
      end
      repeat (4) @(posedge clk);
      wr(8'h00, 32'h2);
      repeat (2) @(posedge clk);
      chk("active", 1'b0, scanActive);
      wr(8'h00, 32'h1);
      repeat (6) @(posedge clk);
      chk("active", 1'b0, scanActive);
      wr(8'h1C, 32'h3);
      wr(8'h00, 32'h1);
      repeat (4) @(posedge clk);
      chk("active", 1'b1, scanActive);
      wr(8'h00, 32'h2);
      repeat (3) @(posedge clk);
      for (k = 0; k < 4; k++) expC.push_back(ch[k % 3]);
      expC.push_back(ch[0]);
      expO = expC;
      chkSeq();
      $display("test continuous stop done");
      // External trigger advance, interface clear keeps the list usable
      wr(8'h1C, 32'h3);
      wr(8'h04, 32'h6);
      wr(8'h00, 32'h1);
      repeat (6) @(posedge clk);
      extTrigPin <= 1'b1;
      repeat (8) @(posedge clk);
      extTrigPin <= 1'b0;
      repeat (8) @(posedge clk);
      ifcClearPin <= 1'b1;
      waitIdle();
      ifcClearPin <= 1'b0;
      wr(8'h00, 32'h1);
      repeat (6) @(posedge clk);
      wr(8'h00, 32'h2);
      repeat (3) @(posedge clk);
      expC = '{ch[0], ch[1], ch[0]};
      expO = expC;
      chkSeq();
      $display("test trigger and clear done");
      summarize();
   end
endmodule // tb_top
bind scc_top scc_top_sva chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .chanCloseStb(chanCloseStb), .scanActive(scanActive), .monCard(monCard));
